// ==== core/orl_pkg.sv ====
// Constants, types and layouts shared by the on-screen display RAM loader.
// Assumes a single system clock domain for users of the register fields.
package orl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Memory organisation
  localparam int FONT_RAM_COUNT = 8;
  localparam int SEG_W = 4;
  localparam int LINE_W = 4;
  localparam int FONT_DOT_W = 5;
  localparam int FONT_DEPTH = 256;
  localparam int ROW_W = 4;
  localparam int COL_W = 5;
  localparam int DISP_ROWS = 11;
  localparam int DISP_COLS = 32;
  localparam int DISP_DEPTH = DISP_ROWS * DISP_COLS;
  localparam logic [3:0] LAST_DATA_ROW = 4'h9;
  localparam logic [3:0] CTRL_ROW = 4'ha;
  localparam logic [4:0] LAST_CELL_COL = 5'h17;
  localparam logic [4:0] ROW_FMT_A_COL = 5'h1e;
  localparam logic [4:0] ROW_FMT_B_COL = 5'h1f;
  localparam logic [4:0] LAST_CTRL_COL = 5'h0c;
  localparam logic [4:0] LAST_COL = 5'h1f;
  localparam logic [3:0] LAST_LINE = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Address byte tags
  localparam logic [1:0] TAG_SEGMENT = 2'h3;
  localparam logic [1:0] TAG_ROW = 2'h2;
  localparam logic [1:0] TAG_LINE_EXPL = 2'h0;
  localparam logic [1:0] TAG_LINE_STREAM = 2'h1;
  localparam int ADDR_ROW_BIT = 7;
  localparam int STREAM_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Control register columns of the control row and field positions
  localparam logic [4:0] WIN1_ROWS_COL = 5'h00;
  localparam logic [4:0] WIN1_START_COL = 5'h01;
  localparam logic [4:0] WIN1_END_COL = 5'h02;
  localparam logic [4:0] FRAME_CTRL_COL = 5'h0c;
  localparam int COLOR_PICK_BIT = 7;
  localparam int TALL_BIT = 1;
  localparam int WIDE_BIT = 0;
  localparam int WIN_EN_BIT = 2;
  localparam int WIN_PAL_BIT = 1;
  localparam int HSYNC_POLARITY_BIT = 0;
  localparam int OVERLAY_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] FIRST_ROM_GLYPH = 7'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } orl_link_word_s;

  typedef enum {
    ST_IDLE,
    ST_HAVE_HI,
    ST_HAVE_LOC,
    ST_AFTER_INFO,
    ST_STREAM
  } orl_state_e;

endpackage

// ==== core/orl_link_xfer.sv ====
// Carries received bytes from the serial front end clock into the system clock.
// Assumes the front end offers one byte per pulse and honours link_busy.
`timescale 1ns/1ps
module orl_link_xfer (
  input wire logic link_clk,
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_frame_start,
  input wire logic link_byte_valid,
  input wire logic [7:0] link_byte,
  output logic link_busy,
  output logic word_valid,
  output orl_pkg::orl_link_word_s word
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain
  orl_pkg::orl_link_word_s hold_q;
  logic req_q;
  logic first_pend_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic busy_q;
  logic ack_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic take;

  assign take = link_byte_valid & ~busy_q;

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= '0;
      req_q <= 1'b0;
      first_pend_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      busy_q <= take | (busy_q & (req_q != ack_s2_q));
      if (take) begin
        hold_q <= '{first: first_pend_q | link_frame_start, data: link_byte};
        req_q <= ~req_q;
        first_pend_q <= 1'b0;
      end else if (link_frame_start) begin
        first_pend_q <= 1'b1;
      end
    end
  end

  assign link_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // System domain
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q <= 1'b0;
      word_valid <= 1'b0;
      word <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_q <= req_s3_q;
      word_valid <= req_s2_q ^ req_s3_q;
      if (req_s2_q ^ req_s3_q) begin
        word <= hold_q;
      end
    end
  end

endmodule

// ==== core/orl_ram_loader.sv ====
// Byte-stream interpreter that loads font RAM, display RAM and control registers.
// Assumes a serial slave front end on link_clk delivering whole bytes and
// a display engine on mclk reading the memories through the read ports.
//
// Contract
// - Eight writable fonts 0..7, each two segments by sixteen lines.
// - Font information stores low five bits, upper three ignored.
// - Segment and line addresses are four bits each.
// - Explicit format: segment, line, then information written there.
// - Streaming format treats all later bytes as information, auto-incrementing.
// - Tag 11 segment, 00 explicit line, 01 streaming line.
// - Glyph codes 8..127 are fixed glyphs above the writable range.
// - Cells rows 0..9, columns 0..23 hold the displayed glyph code.
// - Columns 30 and 31 of each data row hold its format.
// - Window and frame registers sit in row 10 columns 0..12.
// - A tall memory row fills two screen rows, no filler row.
// - Wide rows show even columns only, odd columns skipped.
// - Cell bit 7 picks first or second row colour.
// - Cell bits 6..0 form the seven-bit glyph index.
// - Format A: bits 7..2 colours, bit 1 tall, bit 0 wide.
// - Format B bits 7..2 give third and fourth colours.
// - Window 1 start bit 2 enables it, bit 1 extra palette.
// - Window 1 start bit 0 is hsync polarity, zero at reset.
// - Window 1 uses row 10 columns 0..2.
// - Window hidden when start exceeds end; end bits 2..0 colour.
// - Row address has bit 7 set; column bit 6 starts streaming.
`timescale 1ns/1ps
module orl_ram_loader #(
  parameter int DOT_W = orl_pkg::FONT_DOT_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_frame_start,
  input wire logic link_byte_valid,
  input wire logic [7:0] link_byte,
  output logic link_busy,
  input wire logic [3:0] disp_rd_row,
  input wire logic [4:0] disp_rd_col,
  output logic [6:0] glyph_index,
  output logic char_color_pick,
  output logic glyph_in_ram,
  output logic cell_hidden,
  output logic tall_row,
  output logic wide_row,
  output logic [5:0] row_colors_a,
  output logic [5:0] row_colors_b,
  input wire logic [3:0] font_rd_segment,
  input wire logic [3:0] font_rd_line,
  output logic [DOT_W-1:0] font_dots,
  input wire logic scan_frame_start,
  input wire logic scan_row_step,
  output logic [3:0] scan_mem_row,
  output logic win1_enable,
  output logic window_extra_palette,
  output logic [2:0] win1_color,
  output logic [3:0] win1_row_start,
  output logic [3:0] win1_row_end,
  output logic [4:0] win1_col_start,
  output logic [4:0] win1_col_end,
  output logic win1_visible,
  output logic hsync_polarity,
  input wire logic hsync_input,
  output logic hsync_active,
  output logic overlay_activate
);

  function automatic logic [8:0] cell_index(input logic [3:0] row, input logic [4:0] col);
    cell_index = 9'({row, 5'h00}) + 9'(col);
  endfunction

  function automatic logic is_stored_cell(input logic [3:0] row, input logic [4:0] col);
    logic data_cell;
    logic fmt_cell;
    logic ctrl_cell;
    data_cell = (row <= orl_pkg::LAST_DATA_ROW) && (col <= orl_pkg::LAST_CELL_COL);
    fmt_cell = (row <= orl_pkg::LAST_DATA_ROW) &&
               ((col == orl_pkg::ROW_FMT_A_COL) || (col == orl_pkg::ROW_FMT_B_COL));
    ctrl_cell = (row == orl_pkg::CTRL_ROW) && (col <= orl_pkg::LAST_CTRL_COL);
    is_stored_cell = data_cell | fmt_cell | ctrl_cell;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link crossing
  logic word_valid;
  orl_pkg::orl_link_word_s word;

  orl_link_xfer u_xfer (
    .link_clk(link_clk),
    .mclk(mclk),
    .sys_rst(sys_rst),
    .link_frame_start(link_frame_start),
    .link_byte_valid(link_byte_valid),
    .link_byte(link_byte),
    .link_busy(link_busy),
    .word_valid(word_valid),
    .word(word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte interpreter
  orl_pkg::orl_state_e state_q;
  logic font_space_q;
  logic [3:0] hi_addr_q;
  logic [4:0] lo_addr_q;
  logic [7:0] b;
  logic [1:0] tag;
  logic is_hi;
  logic is_lo;
  logic info_now;
  orl_pkg::orl_state_e st;

  assign b = word.data;
  assign tag = b[7:6];
  assign is_hi = (tag == orl_pkg::TAG_SEGMENT) || (tag == orl_pkg::TAG_ROW);
  assign is_lo = ~b[orl_pkg::ADDR_ROW_BIT];
  // A new transmission restarts the sequence
  assign st = word.first ? orl_pkg::ST_IDLE : state_q;
  assign info_now = word_valid && ((st == orl_pkg::ST_HAVE_LOC) || (st == orl_pkg::ST_STREAM));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= orl_pkg::ST_IDLE;
      font_space_q <= 1'b0;
      hi_addr_q <= 4'h0;
      lo_addr_q <= 5'h00;
    end else if (word_valid) begin
      case (st)
        orl_pkg::ST_IDLE, orl_pkg::ST_AFTER_INFO: begin
          if (is_hi) begin
            font_space_q <= (tag == orl_pkg::TAG_SEGMENT);
            hi_addr_q <= b[3:0];
            state_q <= orl_pkg::ST_HAVE_HI;
          end else if (is_lo && (st == orl_pkg::ST_AFTER_INFO)) begin
            lo_addr_q <= font_space_q ? {1'b0, b[3:0]} : b[4:0];
            state_q <= b[orl_pkg::STREAM_BIT] ? orl_pkg::ST_STREAM : orl_pkg::ST_HAVE_LOC;
          end else begin
            state_q <= st;
          end
        end
        orl_pkg::ST_HAVE_HI: begin
          // Column or line, bit 6 streams
          lo_addr_q <= font_space_q ? {1'b0, b[3:0]} : b[4:0];
          state_q <= b[orl_pkg::STREAM_BIT] ? orl_pkg::ST_STREAM : orl_pkg::ST_HAVE_LOC;
        end
        orl_pkg::ST_HAVE_LOC: begin
          state_q <= orl_pkg::ST_AFTER_INFO;
        end
        orl_pkg::ST_STREAM: begin
          state_q <= orl_pkg::ST_STREAM;
          if (font_space_q) begin
            lo_addr_q <= {1'b0, lo_addr_q[3:0] + 4'h1};
            if (lo_addr_q[3:0] == orl_pkg::LAST_LINE) begin
              hi_addr_q <= hi_addr_q + 4'h1;
            end
          end else begin
            lo_addr_q <= lo_addr_q + 5'h01;
            if (lo_addr_q == orl_pkg::LAST_COL) begin
              hi_addr_q <= hi_addr_q + 4'h1;
            end
          end
        end
        default: begin
          state_q <= orl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Font RAM
  logic [DOT_W-1:0] font_mem [0:orl_pkg::FONT_DEPTH-1];

  always_ff @(posedge mclk) begin
    if (info_now && font_space_q) begin
      font_mem[{hi_addr_q, lo_addr_q[3:0]}] <= b[DOT_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      font_dots <= '0;
    end else begin
      font_dots <= font_mem[{font_rd_segment, font_rd_line}];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display RAM and control registers
  logic [7:0] disp_mem [0:orl_pkg::DISP_DEPTH-1];
  logic disp_we;

  assign disp_we = info_now && !font_space_q && is_stored_cell(hi_addr_q, lo_addr_q);

  always_ff @(posedge mclk) begin
    if (disp_we) begin
      disp_mem[cell_index(hi_addr_q, lo_addr_q)] <= b;
    end
  end

  logic [7:0] rd_cell;
  logic [7:0] rd_fmt_a;
  logic [7:0] rd_fmt_b;
  logic rd_ok;

  assign rd_ok = is_stored_cell(disp_rd_row, disp_rd_col) && (disp_rd_row != orl_pkg::CTRL_ROW);
  assign rd_cell = rd_ok ? disp_mem[cell_index(disp_rd_row, disp_rd_col)] : 8'h00;
  assign rd_fmt_a = rd_ok ? disp_mem[cell_index(disp_rd_row, orl_pkg::ROW_FMT_A_COL)] : 8'h00;
  assign rd_fmt_b = rd_ok ? disp_mem[cell_index(disp_rd_row, orl_pkg::ROW_FMT_B_COL)] : 8'h00;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      glyph_index <= 7'h00;
      char_color_pick <= 1'b0;
      glyph_in_ram <= 1'b0;
      cell_hidden <= 1'b0;
      tall_row <= 1'b0;
      wide_row <= 1'b0;
      row_colors_a <= 6'h00;
      row_colors_b <= 6'h00;
    end else begin
      glyph_index <= rd_cell[6:0];
      char_color_pick <= rd_cell[orl_pkg::COLOR_PICK_BIT];
      glyph_in_ram <= rd_cell[6:0] < orl_pkg::FIRST_ROM_GLYPH;
      cell_hidden <= rd_fmt_a[orl_pkg::WIDE_BIT] & disp_rd_col[0];
      tall_row <= rd_fmt_a[orl_pkg::TALL_BIT];
      wide_row <= rd_fmt_a[orl_pkg::WIDE_BIT];
      row_colors_a <= rd_fmt_a[7:2];
      row_colors_b <= rd_fmt_b[7:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Screen row to memory row
  logic half_q;
  logic cur_tall;

  assign cur_tall = disp_mem[cell_index(scan_mem_row, orl_pkg::ROW_FMT_A_COL)][orl_pkg::TALL_BIT];

  // Tall row spans two screen rows
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_mem_row <= 4'h0;
      half_q <= 1'b0;
    end else if (scan_frame_start) begin
      scan_mem_row <= 4'h0;
      half_q <= 1'b0;
    end else if (scan_row_step && (scan_mem_row <= orl_pkg::LAST_DATA_ROW)) begin
      if (cur_tall && !half_q) begin
        half_q <= 1'b1;
      end else begin
        half_q <= 1'b0;
        scan_mem_row <= scan_mem_row + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window 1 and frame control copies
  logic ctrl_we;

  assign ctrl_we = disp_we && (hi_addr_q == orl_pkg::CTRL_ROW);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      win1_row_start <= orl_pkg::CTRL_RESET[7:4];
      win1_row_end <= orl_pkg::CTRL_RESET[3:0];
      win1_col_start <= orl_pkg::CTRL_RESET[7:3];
      win1_col_end <= orl_pkg::CTRL_RESET[7:3];
      win1_enable <= 1'b0;
      window_extra_palette <= 1'b0;
      hsync_polarity <= 1'b0;
      win1_color <= orl_pkg::CTRL_RESET[2:0];
      overlay_activate <= 1'b0;
    end else if (ctrl_we) begin
      if (lo_addr_q == orl_pkg::WIN1_ROWS_COL) begin
        win1_row_start <= b[7:4];
        win1_row_end <= b[3:0];
      end else if (lo_addr_q == orl_pkg::WIN1_START_COL) begin
        win1_col_start <= b[7:3];
        win1_enable <= b[orl_pkg::WIN_EN_BIT];
        window_extra_palette <= b[orl_pkg::WIN_PAL_BIT];
        hsync_polarity <= b[orl_pkg::HSYNC_POLARITY_BIT];
      end else if (lo_addr_q == orl_pkg::WIN1_END_COL) begin
        win1_col_end <= b[7:3];
        win1_color <= b[2:0];
      end else if (lo_addr_q == orl_pkg::FRAME_CTRL_COL) begin
        overlay_activate <= b[orl_pkg::OVERLAY_BIT];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      win1_visible <= 1'b0;
    end else begin
      win1_visible <= win1_enable && (win1_row_start <= win1_row_end) &&
                      (win1_col_start <= win1_col_end);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal sync input
  logic hs_s1_q;
  logic hs_s2_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_s1_q <= 1'b0;
      hs_s2_q <= 1'b0;
      hsync_active <= 1'b0;
    end else begin
      hs_s1_q <= hsync_input;
      hs_s2_q <= hs_s1_q;
      hsync_active <= hsync_polarity ? hs_s2_q : ~hs_s2_q;
    end
  end

endmodule

// ==== bench/orl_loader_checker.sv ====
// Concurrent checks on the ports of the RAM loader top module.
// Assumes mclk and link_clk domains share the asynchronous sys_rst.
`timescale 1ns/1ps
module orl_loader_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_byte_valid,
  input wire logic link_busy,
  input wire logic [3:0] disp_rd_row,
  input wire logic [4:0] disp_rd_col,
  input wire logic [6:0] glyph_index,
  input wire logic char_color_pick,
  input wire logic glyph_in_ram,
  input wire logic cell_hidden,
  input wire logic tall_row,
  input wire logic wide_row,
  input wire logic [5:0] row_colors_a,
  input wire logic scan_frame_start,
  input wire logic [3:0] scan_mem_row,
  input wire logic win1_enable,
  input wire logic [3:0] win1_row_start,
  input wire logic [3:0] win1_row_end,
  input wire logic [4:0] win1_col_start,
  input wire logic [4:0] win1_col_end,
  input wire logic win1_visible,
  input wire logic hsync_polarity,
  input wire logic hsync_input,
  input wire logic hsync_active
);
  logic [2:0] warm_q;

  // Cycles since reset, so pipeline checks skip their fill time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      warm_q <= 3'h0;
    end else if (warm_q != 3'h7) begin
      warm_q <= warm_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  link_take_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_byte_valid && !link_busy |=> link_busy) else $error("busy not raised after take");
  win_visible_a: assert property (@(posedge mclk) disable iff (sys_rst)
    win1_visible == $past(win1_enable && (win1_row_start <= win1_row_end) &&
    (win1_col_start <= win1_col_end))) else $error("window visibility wrong");
  hsync_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    warm_q == 3'h7 && hsync_polarity == $past(hsync_polarity, 3) |->
    hsync_active == ($past(hsync_input, 3) ~^ hsync_polarity)) else $error("hsync wrong");
  scan_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    scan_frame_start |=> scan_mem_row == 4'h0) else $error("scan row not restarted");
  scan_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(scan_frame_start) |-> scan_mem_row == $past(scan_mem_row) ||
    scan_mem_row == $past(scan_mem_row) + 4'h1) else $error("scan row jumped");
  scan_limit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    scan_mem_row <= 4'ha) else $error("scan row beyond limit");
  odd_hidden_a: assert property (@(posedge mclk) disable iff (sys_rst)
    cell_hidden |-> wide_row && $past(disp_rd_col[0])) else $error("cell hidden wrongly");
  ram_glyph_a: assert property (@(posedge mclk) disable iff (sys_rst)
    glyph_in_ram |-> glyph_index < 7'h08) else $error("fixed glyph flagged as ram");
  gap_cols_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(disp_rd_col) >= 5'h18 && $past(disp_rd_col) <= 5'h1d |->
    glyph_index == 7'h00 && !char_color_pick) else $error("unstored cell not zero");
  ctrl_row_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(disp_rd_row) >= 4'ha |-> row_colors_a == 6'h00 && !tall_row)
    else $error("format read on control row");

  cover property (@(posedge mclk) disable iff (sys_rst) $rose(win1_visible));
  cover property (@(posedge mclk) disable iff (sys_rst) cell_hidden);
  cover property (@(posedge mclk) disable iff (sys_rst) $rose(scan_mem_row == 4'h2));
  cover property (@(posedge link_clk) disable iff (sys_rst) link_byte_valid && !link_busy);
endmodule

bind orl_ram_loader orl_loader_checker chk (.mclk, .sys_rst, .link_clk, .link_byte_valid,
  .link_busy, .disp_rd_row, .disp_rd_col, .glyph_index, .char_color_pick, .glyph_in_ram,
  .cell_hidden, .tall_row, .wide_row, .row_colors_a, .scan_frame_start, .scan_mem_row,
  .win1_enable, .win1_row_start, .win1_row_end, .win1_col_start, .win1_col_end,
  .win1_visible, .hsync_polarity, .hsync_input, .hsync_active);

// ==== bench/orl_host_model.sv ====
// Host side of the link: offers one byte at a time on link_clk.
// Assumes the loader raises link_busy after each taken byte.
`timescale 1ns/1ps
module orl_host_model (
  input wire logic link_clk,
  input wire logic link_busy,
  output logic link_frame_start,
  output logic link_byte_valid,
  output logic [7:0] link_byte
);
  initial begin
    link_frame_start = 1'b0;
    link_byte_valid = 1'b0;
    link_byte = 8'h00;
  end

  // One byte per busy-low window, stale data inverted once released
  task automatic send_byte(input logic [7:0] b, input logic first);
    int n;
    n = 0;
    @(posedge link_clk);
    while (link_busy !== 1'b0 && n < 400) begin
      @(posedge link_clk);
      n++;
    end
    #1;
    link_frame_start = first;
    link_byte_valid = 1'b1;
    link_byte = b;
    @(posedge link_clk);
    #1;
    link_frame_start = 1'b0;
    link_byte_valid = 1'b0;
    link_byte = ~b;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench: loads fonts, cells and window registers through the link.
// Assumes the checker is bound to the loader and the host model sends bytes.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic link_frame_start, link_byte_valid, link_busy;
  logic [7:0] link_byte;
  logic [3:0] disp_rd_row = 4'h0;
  logic [4:0] disp_rd_col = 5'h00;
  logic [3:0] font_rd_segment = 4'h0;
  logic [3:0] font_rd_line = 4'h0;
  logic scan_frame_start = 1'b0;
  logic scan_row_step = 1'b0;
  logic hsync_input = 1'b0;
  logic [6:0] glyph_index;
  logic char_color_pick, glyph_in_ram, cell_hidden, tall_row, wide_row;
  logic [5:0] row_colors_a, row_colors_b;
  logic [4:0] font_dots;
  logic [3:0] scan_mem_row, win1_row_start, win1_row_end;
  logic win1_enable, window_extra_palette, win1_visible, hsync_polarity;
  logic hsync_active, overlay_activate;
  logic [2:0] win1_color;
  logic [4:0] win1_col_start, win1_col_end;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  orl_ram_loader dut (.mclk, .sys_rst, .link_clk, .link_frame_start, .link_byte_valid,
    .link_byte, .link_busy, .disp_rd_row, .disp_rd_col, .glyph_index, .char_color_pick,
    .glyph_in_ram, .cell_hidden, .tall_row, .wide_row, .row_colors_a, .row_colors_b,
    .font_rd_segment, .font_rd_line, .font_dots, .scan_frame_start, .scan_row_step,
    .scan_mem_row, .win1_enable, .window_extra_palette, .win1_color, .win1_row_start,
    .win1_row_end, .win1_col_start, .win1_col_end, .win1_visible, .hsync_polarity,
    .hsync_input, .hsync_active, .overlay_activate);
  orl_host_model host (.link_clk, .link_busy, .link_frame_start, .link_byte_valid,
    .link_byte);

  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic txq(input logic [7:0] q[$], input logic first);
    foreach (q[i]) host.send_byte(q[i], first && i == 0);
  endtask
  task automatic rd_cell(input logic [3:0] r, input logic [4:0] c);
    tick(1);
    disp_rd_row = r;
    disp_rd_col = c;
    tick(1);
  endtask
  task automatic rd_font(input logic [3:0] s, input logic [3:0] l, input logic [4:0] e);
    tick(1);
    font_rd_segment = s;
    font_rd_line = l;
    tick(1);
    `CHK(font_dots, e)
  endtask
  task automatic step;
    scan_row_step = 1'b1;
    tick(1);
    scan_row_step = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    sys_rst = 1'b0;
    tick(8);
    `CHK(hsync_polarity, 1'b0)
    `CHK(hsync_active, 1'b1)
    `CHK(overlay_activate, 1'b0)
    // Stray info first, then explicit, shared and streaming font loads
    txq('{8'h1f, 8'hc3, 8'h05, 8'hff}, 1'b1);
    txq('{8'h06, 8'h11, 8'h07, 8'h32}, 1'b0);
    txq('{8'hc2, 8'h4e, 8'h01, 8'h02, 8'hf3}, 1'b0);
    tick(8);
    rd_font(4'h3, 4'h5, 5'h1f);
    rd_font(4'h3, 4'h6, 5'h11);
    rd_font(4'h3, 4'h7, 5'h12);
    rd_font(4'h2, 4'he, 5'h01);
    rd_font(4'h2, 4'hf, 5'h02);
    rd_font(4'h3, 4'h0, 5'h13);
    // A new transmission is the only way out of streaming
    txq('{8'h80, 8'h1e, 8'h00, 8'h81, 8'h05, 8'h85, 8'h1e, 8'h57}, 1'b1);
    txq('{8'h1f, 8'hfc, 8'h06, 8'h10, 8'h8a, 8'h00, 8'h15, 8'h01, 8'h17}, 1'b0);
    txq('{8'h02, 8'h25, 8'h82, 8'h40, 8'h09, 8'h8a}, 1'b0);
    tick(8);
    rd_cell(4'h1, 5'h05);
    `CHK({glyph_index, char_color_pick, glyph_in_ram}, 9'h017)
    `CHK(cell_hidden, 1'b1)
    rd_cell(4'h1, 5'h06);
    `CHK({glyph_index, char_color_pick, glyph_in_ram, cell_hidden}, 10'h080)
    `CHK({row_colors_a, tall_row, wide_row}, 8'h57)
    `CHK(row_colors_b, 6'h3f)
    rd_cell(4'h1, 5'h18);
    `CHK({glyph_index, char_color_pick}, 8'h00)
    rd_cell(4'ha, 5'h01);
    `CHK({row_colors_a, tall_row, wide_row}, 8'h00)
    rd_cell(4'h2, 5'h00);
    `CHK(glyph_index, 7'h09)
    rd_cell(4'h2, 5'h01);
    `CHK({char_color_pick, glyph_index}, 8'h8a)
    `CHK({win1_row_start, win1_row_end, win1_col_start, win1_col_end}, 18'h05444)
    `CHK({win1_enable, window_extra_palette, hsync_polarity}, 3'h7)
    `CHK({win1_color, win1_visible}, 4'hb)
    hsync_input = 1'b1;
    tick(6);
    `CHK(hsync_active, 1'b1)
    hsync_input = 1'b0;
    tick(6);
    `CHK(hsync_active, 1'b0)
    scan_frame_start = 1'b1;
    tick(1);
    scan_frame_start = 1'b0;
    `CHK(scan_mem_row, 4'h0)
    step();
    `CHK(scan_mem_row, 4'h1)
    step();
    `CHK(scan_mem_row, 4'h1)
    step();
    `CHK(scan_mem_row, 4'h2)
    // Start beyond end hides the window; overlay is switched on last
    txq('{8'h8a, 8'h01, 8'h4d, 8'h0c, 8'h80}, 1'b1);
    tick(8);
    `CHK({win1_col_start, win1_visible}, 6'h12)
    `CHK(overlay_activate, 1'b1)
    conclude;
  end
endmodule
